// file: hw/ipc_pkg.sv
// Shared constants, types and decode helpers of the idle and power-down controller.
package ipc_pkg;
   // Bus shape.
   localparam int APB_ADDR_W = 12;
   localparam int APB_DATA_W = 32;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IPC_CTRL_INDEX = 8'h87;
   localparam logic [7:0] IPC_STAT_INDEX = 8'h88;
   localparam logic [11:0] IPC_CTRL_ADDR = {2'b00, IPC_CTRL_INDEX, 2'b00};
   localparam logic [11:0] IPC_STAT_ADDR = {2'b00, IPC_STAT_INDEX, 2'b00};
   // Control register fields.
   localparam int IDLE_BIT = 0;
   localparam int PDOWN_BIT = 1;
   localparam int GF0_BIT = 2;
   localparam int GF1_BIT = 3;
   localparam int BAUD_BIT = 7;
   localparam logic [7:0] IPC_CTRL_RESET = 8'h00;
   localparam logic [7:0] IPC_CTRL_WMASK = 8'h8f;
   // Status register fields.
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_RESET_BIT = 2;
   localparam int STAT_SETTLED_BIT = 3;
   // Timing.
   localparam int CLOCK_HZ = 50_000_000;
   localparam int CLOCK_PERIOD_NS = 20;
   localparam int OSC_PERIOD_NS = 20;
   localparam int RESET_HOLD_OSC_PERIODS = 24;
   localparam int RESET_HOLD_CYCLES =
      (RESET_HOLD_OSC_PERIODS * OSC_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int OSC_SETTLE_MS = 10;
   localparam int OSC_SETTLE_CYCLES = OSC_SETTLE_MS * (CLOCK_HZ / 1000);
   // Operating modes, Gray coded along run, idle, power down, wake.
   typedef enum logic [1:0] {
      IPC_RUN = 2'b00,
      IPC_IDLE = 2'b01,
      IPC_PDOWN = 2'b11,
      IPC_WAKE = 2'b10
   } ipc_mode_type;

   function automatic logic ipc_addr_hit(input logic [11:0] addr, input logic [11:0] target);
      return addr[11:2] == target[11:2];
   endfunction : ipc_addr_hit
endpackage : ipc_pkg

// file: hw/ipc_ctl_if.sv
// Carrier between the controller and its reset filter and oscillator timer.
`timescale 1ns/1ps
interface ipc_ctl_if;
   logic pin_reset_sync;
   logic reset_seen;
   logic settle_start;
   logic settle_done;
   modport filt(output pin_reset_sync, output reset_seen);
   modport timer(input settle_start, output settle_done);
   modport top(input pin_reset_sync, input reset_seen, input settle_done, output settle_start);
endinterface : ipc_ctl_if

// file: hw/ipc_rst_filter.sv
// Synchroniser and minimum-length filter for the external reset pin.
`timescale 1ns/1ps
module ipc_rst_filter #(
   parameter int HOLD_CYCLES = ipc_pkg::RESET_HOLD_CYCLES
) (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic rstn_in,
   // Pin and carrier.
   input wire logic rst_pin_in,
   ipc_ctl_if.filt ctl
);
   import ipc_pkg::*;
   localparam int CW = $clog2(HOLD_CYCLES + 1);
   localparam logic [CW-1:0] HOLD_MAX = CW'(HOLD_CYCLES);
   logic pin_meta;
   logic pin_sync;
   logic [CW-1:0] hold_cnt;
   // Short pulses are ignored for reset_seen, where only an unbroken run counts; pin_reset_sync passes them on unfiltered.
   wire logic [CW-1:0] next_hold_cnt = !pin_sync ? '0 :
      ((hold_cnt == HOLD_MAX) ? hold_cnt : hold_cnt + 1'b1);

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= rst_pin_in;
         pin_sync <= pin_meta;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hold_cnt <= '0;
      end else begin
         hold_cnt <= next_hold_cnt;
      end
   end

   assign ctl.pin_reset_sync = pin_sync;
   assign ctl.reset_seen = (hold_cnt == HOLD_MAX);

   AST_RESET_HOLD: assert property (@(posedge clock_in) disable iff (!rstn_in)
      $rose(ctl.reset_seen) |-> $past(pin_sync, 1) && $past(pin_sync, 24))
      else $error("Reset accepted before the pin was held long enough.");
endmodule : ipc_rst_filter

// file: hw/ipc_osc_timer.sv
// Oscillator restart timer used when power down is left by reset.
`timescale 1ns/1ps
module ipc_osc_timer #(
   parameter int SETTLE_CYCLES = ipc_pkg::OSC_SETTLE_CYCLES
) (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic rstn_in,
   // Carrier.
   ipc_ctl_if.timer ctl
);
   import ipc_pkg::*;
   localparam int CW = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CW-1:0] SETTLE_MAX = CW'(SETTLE_CYCLES);
   logic [CW-1:0] settle_cnt;
   wire logic [CW-1:0] next_settle_cnt = ctl.settle_start ? SETTLE_MAX :
      ((settle_cnt == '0) ? settle_cnt : settle_cnt - 1'b1);

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         settle_cnt <= '0;
      end else begin
         settle_cnt <= next_settle_cnt;
      end
   end

   assign ctl.settle_done = (settle_cnt == '0);

   AST_SETTLE_WAIT: assert property (@(posedge clock_in) disable iff (!rstn_in)
      ctl.settle_start |=> !ctl.settle_done [*2])
      else $error("Oscillator reported settled too soon after restart.");
endmodule : ipc_osc_timer

// file: hw/ipc_top.sv
// Idle and power-down controller with its APB register file.
`timescale 1ns/1ps
module ipc_top #(
   parameter int HOLD_CYCLES = ipc_pkg::RESET_HOLD_CYCLES,
   parameter int SETTLE_CYCLES = ipc_pkg::OSC_SETTLE_CYCLES
) (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic rstn_in,
   // APB slave.
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ipc_pkg::APB_ADDR_W-1:0] paddr_in,
   input wire logic [ipc_pkg::APB_DATA_W-1:0] pwdata_in,
   output logic [ipc_pkg::APB_DATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Reset pin and interrupt logic.
   input wire logic rst_pin_in,
   input wire logic irq_pending_in,
   // Strobes from the CPU core.
   input wire logic core_ale_in,
   input wire logic core_program_store_strobe_in,
   // Clock enables and reset towards the core.
   output logic cpu_clk_en_out,
   output logic periph_clk_en_out,
   output logic osc_run_out,
   output logic core_rst_out,
   output logic irq_wake_out,
   // Pin control.
   output logic port_latch_out,
   output logic port_reg_drive_out,
   output logic ale_out,
   output logic program_store_strobe_out,
   output logic baud_doubler_out
);
   import ipc_pkg::*;

   ipc_ctl_if ctl();
   ipc_mode_type mode;
   ipc_mode_type next_mode;
   logic [7:0] power_mode_control;
   logic [7:0] next_power_mode_control;
   logic [APB_DATA_W-1:0] next_prdata;
   logic irq_wake;

   ipc_rst_filter #(.HOLD_CYCLES(HOLD_CYCLES)) u_filter (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .rst_pin_in(rst_pin_in),
      .ctl(ctl.filt)
   );

   ipc_osc_timer #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_timer (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .ctl(ctl.timer)
   );

   // Bus decode.
   wire logic apb_setup = psel_in && !penable_in;
   wire logic apb_access = psel_in && penable_in;
   wire logic hit_ctrl = ipc_addr_hit(paddr_in, IPC_CTRL_ADDR);
   wire logic hit_stat = ipc_addr_hit(paddr_in, IPC_STAT_ADDR);
   wire logic hit_any = hit_ctrl || hit_stat;
   // The CPU is the only writer, so writes outside run mode are dropped.
   wire logic ctrl_write = apb_access && pwrite_in && hit_ctrl && (mode == IPC_RUN);
   wire logic wr_idle = pwdata_in[IDLE_BIT];
   wire logic wr_pdown = pwdata_in[PDOWN_BIT];
   wire logic sfr_reset = ctl.reset_seen || (mode == IPC_WAKE);
   wire logic idle_irq = (mode == IPC_IDLE) && irq_pending_in && !ctl.reset_seen;
   wire logic [7:0] ctrl_read = power_mode_control & IPC_CTRL_WMASK;
   wire logic [7:0] stat_read = {4'h0, ctl.settle_done, ctl.reset_seen, mode};

   assign pready_out = 1'b1;
   assign pslverr_out = apb_access && !hit_any;

   // Read data is captured in the setup cycle, so it stands for the access phase.
   assign next_prdata = !apb_setup ? prdata_out :
      (hit_ctrl ? {24'h000000, ctrl_read} :
      (hit_stat ? {24'h000000, stat_read} : 32'h00000000));

   always_comb begin
      next_power_mode_control = power_mode_control;
      if (sfr_reset) begin
         next_power_mode_control = IPC_CTRL_RESET;
      end else if (ctrl_write) begin
         next_power_mode_control = pwdata_in[7:0] & IPC_CTRL_WMASK;
      end else if (idle_irq) begin
         next_power_mode_control[IDLE_BIT] = 1'b0;
      end
   end

   always_comb begin
      next_mode = mode;
      case (mode)
         IPC_RUN: begin
            if (ctrl_write && wr_pdown) begin
               next_mode = IPC_PDOWN;
            end else if (ctrl_write && wr_idle) begin
               next_mode = IPC_IDLE;
            end
         end
         IPC_IDLE: begin
            if (ctl.reset_seen || irq_pending_in) begin
               next_mode = IPC_RUN;
            end
         end
         IPC_PDOWN: begin
            if (ctl.pin_reset_sync) begin
               next_mode = IPC_WAKE;
            end
         end
         IPC_WAKE: begin
            // Waiting for the pin too keeps the core reset free of gaps on a long hold.
            if (ctl.settle_done && !ctl.pin_reset_sync) begin
               next_mode = IPC_RUN;
            end
         end
         default: begin
            next_mode = IPC_RUN;
         end
      endcase
   end

   assign ctl.settle_start = (mode == IPC_PDOWN) && (next_mode == IPC_WAKE);

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mode <= IPC_RUN;
         power_mode_control <= IPC_CTRL_RESET;
      end else begin
         mode <= next_mode;
         power_mode_control <= next_power_mode_control;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata_out <= 32'h00000000;
         irq_wake <= 1'b0;
      end else begin
         prdata_out <= next_prdata;
         irq_wake <= idle_irq;
      end
   end

   // Stopping the enable freezes every CPU register, PC and stack pointer included.
   assign cpu_clk_en_out = (mode == IPC_RUN);
   assign periph_clk_en_out = (mode == IPC_RUN) || (mode == IPC_IDLE);
   assign osc_run_out = (mode != IPC_PDOWN);
   assign core_rst_out = sfr_reset;
   // The core resumes at the step after the idle entry once the handler returns.
   assign irq_wake_out = irq_wake;
   assign port_latch_out = (mode == IPC_IDLE);
   assign port_reg_drive_out = (mode == IPC_PDOWN);
   assign ale_out = (mode == IPC_IDLE) ? 1'b1 :
      ((mode == IPC_PDOWN) ? 1'b0 : core_ale_in);
   assign program_store_strobe_out = (mode == IPC_IDLE) ? 1'b1 :
      ((mode == IPC_PDOWN) ? 1'b0 : core_program_store_strobe_in);
   assign baud_doubler_out = power_mode_control[BAUD_BIT];

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   AST_PD_PRECEDENCE: assert property (
      ctrl_write && wr_idle && wr_pdown |=> mode == IPC_PDOWN && !osc_run_out)
      else $error("Power down did not take precedence over idle.");

   AST_IDLE_ENTRY: assert property (
      ctrl_write && wr_idle && !wr_pdown && !ctl.reset_seen
      |-> cpu_clk_en_out ##1 !cpu_clk_en_out && periph_clk_en_out && osc_run_out)
      else $error("Idle entry did not stop only the CPU clock after the write.");

   AST_PD_STOPPED: assert property (
      mode == IPC_PDOWN |-> !osc_run_out && !periph_clk_en_out && !cpu_clk_en_out)
      else $error("A clock still runs in power down.");

   AST_IDLE_PINS: assert property (
      mode == IPC_IDLE |-> ale_out && program_store_strobe_out && port_latch_out)
      else $error("Strobes or port hold wrong in idle.");

   AST_PD_PINS: assert property (
      mode == IPC_PDOWN |-> !ale_out && !program_store_strobe_out && port_reg_drive_out)
      else $error("Strobes or port drive wrong in power down.");

   AST_IRQ_WAKE: assert property (
      idle_irq |=> cpu_clk_en_out && irq_wake_out && !power_mode_control[IDLE_BIT])
      else $error("Interrupt did not end idle.");

   AST_RESET_CLEAR: assert property (
      sfr_reset |=> power_mode_control[BAUD_BIT] == 1'b0 && power_mode_control[3:0] == 4'h0)
      else $error("Reset did not clear the control register.");

   AST_PD_EXIT: assert property (
      mode == IPC_PDOWN && !ctl.pin_reset_sync |=> mode == IPC_PDOWN)
      else $error("Power down left without reset.");

   AST_FLAG_READBACK: assert property (
      ctrl_write && !sfr_reset ##2 apb_setup && hit_ctrl && !sfr_reset
      |=> prdata_out[GF1_BIT:GF0_BIT] == $past(pwdata_in[GF1_BIT:GF0_BIT], 3))
      else $error("General flags did not read back as written.");

   AST_WAKE_HOLD: assert property (
      mode == IPC_WAKE && ctl.pin_reset_sync |=> core_rst_out)
      else $error("Core reset dropped while the reset pin was still held.");

   AST_RESERVED_READ: assert property (
      apb_access && !pwrite_in |-> prdata_out[31:8] == 24'h000000 && prdata_out[6:4] == 3'h0)
      else $error("Reserved read bits are not zero.");

   COV_IDLE_ENTRY: cover property (mode == IPC_RUN ##1 mode == IPC_IDLE);
   COV_IRQ_WAKE: cover property (idle_irq ##1 mode == IPC_RUN);
   COV_PD_ENTRY: cover property (mode == IPC_RUN ##1 mode == IPC_PDOWN);
   COV_PD_WAKE: cover property (mode == IPC_WAKE ##1 mode == IPC_RUN);
endmodule : ipc_top

// file: test/ipc_far_model.sv
// Far-side model: core strobes, interrupt source and external reset pin.
`timescale 1ns/1ps
module ipc_far_model (
   // Clock.
   input wire logic clock_in,
   // Feedback from the controller.
   input wire logic cpu_clk_en_in,
   input wire logic irq_wake_in,
   // Towards the controller.
   output logic irq_pending_out,
   output logic rst_pin_out,
   output logic core_ale_out,
   output logic core_pss_out
);
   logic [1:0] phase = 2'b00;
   initial begin
      irq_pending_out = 1'b0;
      rst_pin_out = 1'b0;
   end
   // The core strobes move only while the core gets its clock.
   always @(posedge clock_in) begin
      if (cpu_clk_en_in) begin
         phase <= phase + 2'b01;
      end
   end
   assign core_ale_out = phase[0];
   assign core_pss_out = phase[1];
   // A level interrupt stays up until the controller reports it taken.
   always @(posedge clock_in) begin
      if (irq_wake_in) begin
         irq_pending_out <= 1'b0;
      end
   end
   task raise_irq(input logic level);
      @(posedge clock_in);
      irq_pending_out <= level;
   endtask : raise_irq
   // The pin is held for the given count, so a short one can test the filter.
   task hold_reset(input int cycles);
      @(posedge clock_in);
      rst_pin_out <= 1'b1;
      repeat (cycles) @(posedge clock_in);
      rst_pin_out <= 1'b0;
   endtask : hold_reset
endmodule : ipc_far_model

// file: test/tb.sv
// Self-checking testbench of the idle and power-down controller.
`timescale 1ns/1ps
module tb;
   import ipc_pkg::*;
   localparam int SETTLE = 20;
   logic clock_in;
   logic rstn_in;
   logic psel_in;
   logic penable_in;
   logic pwrite_in;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in;
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out, rst_pin, irq_pend, c_ale, c_pss;
   logic cpu_clk_en_out, periph_clk_en_out, osc_run_out, core_rst_out, irq_wake_out;
   logic port_latch_out, port_reg_drive_out, ale_out, pss_out, baud_doubler_out;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [31:0] r;
   logic e, seen;
   int n, m;

   ipc_top #(.HOLD_CYCLES(24), .SETTLE_CYCLES(SETTLE)) dut (
      .clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .rst_pin_in(rst_pin), .irq_pending_in(irq_pend), .core_ale_in(c_ale),
      .core_program_store_strobe_in(c_pss), .cpu_clk_en_out(cpu_clk_en_out),
      .periph_clk_en_out(periph_clk_en_out), .osc_run_out(osc_run_out),
      .core_rst_out(core_rst_out), .irq_wake_out(irq_wake_out),
      .port_latch_out(port_latch_out), .port_reg_drive_out(port_reg_drive_out),
      .ale_out(ale_out), .program_store_strobe_out(pss_out),
      .baud_doubler_out(baud_doubler_out));
   ipc_far_model far (
      .clock_in(clock_in), .cpu_clk_en_in(cpu_clk_en_out), .irq_wake_in(irq_wake_out),
      .irq_pending_out(irq_pend), .rst_pin_out(rst_pin), .core_ale_out(c_ale),
      .core_pss_out(c_pss));

   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : chk

   // The request is held until pready is sampled high; read data is taken at that edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      @(posedge clock_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= wd;
      @(posedge clock_in);
      penable_in <= 1'b1;
      // The wait ends when pready is high; only the watchdog ends one that the slave never answers.
      do begin
         @(posedge clock_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic y;
      apb(1'b1, a, d, x, y);
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] x;
      logic y;
      apb(1'b0, a, 32'h00000000, x, y);
      chk(x & mask, exp);
   endtask : rdc

   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   // A hang counts as a mismatch; the full sequence needs well under this span.
   initial begin
      repeat (3000) @(posedge clock_in);
      n_mismatch++;
      give_verdict();
   end

   initial begin
      rstn_in <= 1'b0;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      pwrite_in <= 1'b0;
      paddr_in <= 12'h000;
      pwdata_in <= 32'h00000000;
      repeat (16) @(posedge clock_in);
      rstn_in <= 1'b1;
      rdc(IPC_CTRL_ADDR, 32'hffffffff, 32'h00000000);
      chk({cpu_clk_en_out, periph_clk_en_out, osc_run_out}, 3'b111);
      chk(baud_doubler_out, 1'b0);
      chk({ale_out, pss_out}, {c_ale, c_pss});
      apb(1'b0, 12'h004, 32'h00000000, r, e);
      chk(e, 1'b1);
      chk(r, 32'h00000000);
      wr(IPC_CTRL_ADDR, 32'h000000fc);
      rdc(IPC_CTRL_ADDR, 32'hffffffff, 32'h0000008c);
      chk(baud_doubler_out, 1'b1);
      far.hold_reset(10);
      seen = 1'b0;
      repeat (40) begin
         @(posedge clock_in);
         seen = seen | core_rst_out;
      end
      chk(seen, 1'b0);
      rdc(IPC_CTRL_ADDR, 32'hffffffff, 32'h0000008c);
      // Idle with both flags, then ended by an interrupt.
      wr(IPC_CTRL_ADDR, 32'h0000000d);
      @(posedge clock_in);
      chk({cpu_clk_en_out, periph_clk_en_out, osc_run_out}, 3'b011);
      chk({ale_out, pss_out, port_latch_out, port_reg_drive_out}, 4'b1110);
      wr(IPC_CTRL_ADDR, 32'h00000002);
      rdc(IPC_CTRL_ADDR, 32'hffffffff, 32'h0000000d);
      far.raise_irq(1'b1);
      n = 0;
      while (irq_wake_out !== 1'b1 && n < 20) begin
         @(posedge clock_in);
         n++;
      end
      chk(n < 20, 1'b1);
      chk(cpu_clk_en_out, 1'b1);
      @(posedge clock_in);
      chk(irq_wake_out, 1'b0);
      rdc(IPC_CTRL_ADDR, 32'hffffffff, 32'h0000000c);
      // Idle ended by a reset of two machine cycles.
      wr(IPC_CTRL_ADDR, 32'h00000001);
      n = 0;
      fork
         far.hold_reset(30);
         while (core_rst_out !== 1'b1 && n < 40) begin
            @(posedge clock_in);
            n++;
         end
      join
      chk(n >= 24 && n <= 28, 1'b1);
      rdc(IPC_CTRL_ADDR, 32'hffffffff, 32'h00000000);
      chk(cpu_clk_en_out, 1'b1);
      // Both bits at once: power down wins, interrupts cannot leave it.
      wr(IPC_CTRL_ADDR, 32'h00000003);
      @(posedge clock_in);
      chk({cpu_clk_en_out, periph_clk_en_out, osc_run_out}, 3'b000);
      chk({ale_out, pss_out, port_latch_out, port_reg_drive_out}, 4'b0001);
      rdc(IPC_STAT_ADDR, 32'h00000003, 32'h00000003);
      far.raise_irq(1'b1);
      repeat (5) @(posedge clock_in);
      chk({osc_run_out, irq_wake_out}, 2'b00);
      far.raise_irq(1'b0);
      rdc(IPC_CTRL_ADDR, 32'hffffffff, 32'h00000003);
      n = 0;
      m = 0;
      fork
         far.hold_reset(40);
         begin
            while (osc_run_out !== 1'b1 && n < 10) begin
               @(posedge clock_in);
               n++;
            end
            chk(core_rst_out, 1'b1);
            while ((core_rst_out !== 1'b0 || cpu_clk_en_out !== 1'b1) && m < 100) begin
               @(posedge clock_in);
               m++;
            end
         end
      join
      chk(m >= SETTLE && m < 100, 1'b1);
      rdc(IPC_CTRL_ADDR, 32'hffffffff, 32'h00000000);
      rdc(IPC_STAT_ADDR, 32'h0000000f, 32'h00000008);
      chk(osc_run_out, 1'b1);
      give_verdict();
   end
endmodule : tb
